// File: testbench/fsam_peer_model.sv
// peer controller on the shared fault pins and source of the sync clock
`timescale 1ns/1ns
`default_nettype none
module fsam_peer_model (
  input wire logic [1:0] fault_pin_oe_n,
  input wire logic [1:0] pull,
  input wire logic sync_en,
  output logic [1:0] fault_pin_in,
  output logic sync_pin
);
  // open-drain wire with pull-up, low if either side pulls
  assign fault_pin_in = fault_pin_oe_n & ~pull;
  // sync clock stands low while disabled
  initial begin
    sync_pin = 1'b0;
    forever begin
      #80;
      sync_pin = sync_en ? ~sync_pin : 1'b0;
    end
  end
endmodule : fsam_peer_model
`default_nettype wire

// File: testbench/tb_fault_status_alert_manager.sv
// self-checking bench of the fault, status and alert manager
`timescale 1ns/1ns
`default_nettype none
module tb_fault_status_alert_manager import fsam_pkg::*;;
  logic core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  fsam_chan_cond_s [1:0] chan_cond;
  fsam_com_cond_s com_cond;
  logic unsafe_cmd, ara_ok, sync_pin, alert_out, alert_oe_n, sync_en;
  logic [1:0] run_pin, fault_pin_in, fault_pin_out, fault_pin_oe_n;
  logic [1:0] chan_en, pull;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int n_errors = 0;
  int n_compared = 0;
  int b;

  fsam_top #(.MS_CYCLES(50)) dut (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chan_cond(chan_cond), .com_cond(com_cond), .unsafe_cmd(unsafe_cmd),
    .ara_ok(ara_ok), .run_pin(run_pin), .sync_pin(sync_pin),
    .fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
    .fault_pin_oe_n(fault_pin_oe_n), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .chan_en(chan_en));

  fsam_peer_model peer (.fault_pin_oe_n(fault_pin_oe_n), .pull(pull),
    .sync_en(sync_en), .fault_pin_in(fault_pin_in), .sync_pin(sync_pin));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // request held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse_cond(input int ch, input int bit_i);
    chan_cond[ch][bit_i] <= 1'b1;
    @(posedge core_clk);
    chan_cond[ch][bit_i] <= 1'b0;
    cyc(4);
  endtask : pulse_cond

  // read data compared at the completing edge
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    chan_cond = '0;
    com_cond = '0;
    {unsafe_cmd, ara_ok, sync_en, pull} = '0;
    run_pin = 2'b11;
    void'($urandom(32'h6267));
    cyc(20);
    rstn <= 1'b1;
    cyc(10);
    rd(OFS_CFG, 32'h4);
    rd(OFS_OPER, 32'h3);
    rd(OFS_RETRY, 32'hfa);
    rd(6'h3c, 32'h0);
    chk(32'(alert_oe_n), 32'h1);
    chk(32'(alert_out), 32'h0);
    chk(32'(fault_pin_out), 32'h0);
    rd(OFS_COMMON, 32'hf);
    // out of range writes leave the interval alone
    wr(OFS_RETRY, 32'd120);
    rd(OFS_RETRY, 32'hfa);
    wr(OFS_RETRY, 32'd83881);
    rd(OFS_RETRY, 32'hfa);
    wr(OFS_RETRY, 32'd83880);
    rd(OFS_RETRY, 32'd83880);
    r = 32'd121 + ($urandom % 32'd83760);
    wr(OFS_RETRY, r);
    rd(OFS_RETRY, r);
    wr(OFS_RETRY, 32'd121);
    // random warning: 1 ov_w, 2 uv_w, 5 oc_w
    b = ($urandom % 3 == 0) ? 5 : (($urandom % 2 == 0) ? 1 : 2);
    pulse_cond(0, b);
    chk(32'(alert_oe_n), 32'h0);
    rd(OFS_WORD, (b == 5) ? 32'h4001 : 32'h8001);
    rd(OFS_STAT0, 32'h1 << b);
    wr(OFS_STAT0, 32'h1 << b);
    cyc(4);
    chk(32'(alert_oe_n), 32'h1);
    wr(OFS_MASK0, 32'h0f);
    pulse_cond(0, 1);
    chk(32'(alert_oe_n), 32'h1);
    rd(OFS_STAT0, 32'h2);
    wr(OFS_STAT0, 32'h2);
    // busy ignores its mask bit
    wr(OFS_MASKC, 32'h3f);
    unsafe_cmd <= 1'b1;
    @(posedge core_clk);
    unsafe_cmd <= 1'b0;
    cyc(4);
    chk(32'(alert_oe_n), 32'h0);
    rd(OFS_STATC, 32'h20);
    ara_ok <= 1'b1;
    @(posedge core_clk);
    ara_ok <= 1'b0;
    cyc(4);
    chk(32'(alert_oe_n), 32'h1);
    for (int i = 0; i < 2; i++) begin
      unsafe_cmd <= 1'b1;
      @(posedge core_clk);
      unsafe_cmd <= 1'b0;
      cyc(4);
      wr(OFS_CTRL, 32'h1 << i);
      rd(OFS_STATC, 32'h0);
    end
    wr(OFS_MASKC, 32'h0);
    // latch-off on channel 0 with the pin driven
    wr(OFS_PROP, 32'h01);
    wr(OFS_RESP, 32'h1);
    wr(OFS_MASK0, 32'h0);
    pulse_cond(0, 0);
    chk(32'(fault_pin_oe_n[0]), 32'h0);
    cyc(50);
    chk(32'(fault_pin_oe_n[0]), 32'h0);
    chk(32'(chan_en[0]), 32'h0);
    chk(32'(alert_oe_n), 32'h0);
    rd(OFS_COMMON, 32'h2b);
    // toggle with clear-all set also empties channel 1
    wr(OFS_CFG, 32'h5);
    pulse_cond(1, 1);
    run_pin[0] <= 1'b0;
    cyc(10);
    run_pin[0] <= 1'b1;
    cyc(10);
    chk(32'(fault_pin_oe_n[0]), 32'h1);
    chk(32'(chan_en[0]), 32'h1);
    chk(32'(alert_oe_n), 32'h1);
    rd(OFS_STAT1, 32'h0);
    // external fault on channel 1, hiccup retry of 121 ms
    wr(OFS_RESP, 32'h0);
    pull[1] <= 1'b1;
    cyc(10);
    pull[1] <= 1'b0;
    cyc(5);
    rd(OFS_STAT1, 32'h80);
    chk(32'(fault_pin_oe_n[1]), 32'h1);
    chk(32'(chan_en[1]), 32'h0);
    wr(OFS_STAT1, 32'h80);
    cyc(5700);
    chk(32'(chan_en[1]), 32'h0);
    cyc(500);
    chk(32'(chan_en[1]), 32'h1);
    // no frequency and no sync clock
    wr(OFS_CFG, 32'h0);
    cyc(60);
    rd(OFS_PADS, 32'h40f);
    rd(OFS_STATC, 32'h10);
    chk(32'(alert_oe_n), 32'h0);
    wr(OFS_CFG, 32'h10);
    rd(OFS_PADS, 32'h00f);
    wr(OFS_CFG, 32'h2);
    rd(OFS_PADS, 32'h00f);
    sync_en <= 1'b1;
    cyc(60);
    wr(OFS_STATC, 32'h10);
    cyc(4);
    rd(OFS_STATC, 32'h0);
    chk(32'(alert_oe_n), 32'h1);
    sync_en <= 1'b0;
    cyc(4);
    chk(exp_q.size(), 0);
    complete_run();
  end
endmodule : tb_fault_status_alert_manager
`default_nettype wire

// File: verilog/fsam_pkg.sv
// constants and types of the fault, status and alert manager
package fsam_pkg;
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CFG = 6'h04;
  localparam logic [5:0] OFS_STAT0 = 6'h08;
  localparam logic [5:0] OFS_STAT1 = 6'h0c;
  localparam logic [5:0] OFS_STATC = 6'h10;
  localparam logic [5:0] OFS_MASK0 = 6'h14;
  localparam logic [5:0] OFS_MASK1 = 6'h18;
  localparam logic [5:0] OFS_MASKC = 6'h1c;
  localparam logic [5:0] OFS_PROP = 6'h20;
  localparam logic [5:0] OFS_RETRY = 6'h24;
  localparam logic [5:0] OFS_RESP = 6'h28;
  localparam logic [5:0] OFS_WORD = 6'h2c;
  localparam logic [5:0] OFS_COMMON = 6'h30;
  localparam logic [5:0] OFS_PADS = 6'h34;
  localparam logic [5:0] OFS_OPER = 6'h38;
  // field positions
  localparam int CTRL_CLR = 0;
  localparam int CTRL_RST = 1;
  localparam int CFG_RUN_CLR_ALL = 0;
  localparam int CFG_EXT_SYNC = 1;
  localparam int CFG_FREQ_SEL = 2;
  localparam int CFG_SYNC_DIS = 4;
  localparam int ST_EXT = 7;
  localparam int C_PLL = 4;
  localparam int C_BUSY = 5;
  localparam int PADS_SYNC_INT = 10;
  // reset values, field masks and retry interval limits
  localparam logic [7:0] CFG_RST = 8'h04;
  localparam logic [1:0] OPER_RST = 2'h3;
  localparam logic [1:0] RESP_RST = 2'h0;
  localparam logic [5:0] COM_UNMASK = 6'h20;
  localparam logic [6:0] SHUT_BITS = 7'h59;
  localparam logic [16:0] RETRY_MIN_MS = 17'h00079;
  localparam logic [16:0] RETRY_MAX_MS = 17'h147a8;
  localparam logic [16:0] RETRY_RST_MS = 17'h000fa;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_TMO_NS = 1000;
  localparam int unsigned SYNC_TMO_CYC = SYNC_TMO_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic ot_f;
    logic iout_oc_w;
    logic iout_oc_f;
    logic vout_uv_f;
    logic vout_uv_w;
    logic vout_ov_w;
    logic vout_ov_f;
  } fsam_chan_cond_s;

  typedef struct packed {
    logic cml;
    logic iin_oc_w;
    logic vin_uv_w;
    logic vin_ov_f;
  } fsam_com_cond_s;

  typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_WAIT, CH_LATCH} fsam_chan_st_e;
endpackage : fsam_pkg

// File: verilog/fsam_top.sv
// fault collection, alert line, fault pins and retry recovery
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module fsam_top import fsam_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire fsam_chan_cond_s [1:0] chan_cond,
  input wire fsam_com_cond_s com_cond,
  input wire logic unsafe_cmd,
  input wire logic ara_ok,
  input wire logic [1:0] run_pin,
  input wire logic sync_pin,
  input wire logic [1:0] fault_pin_in,
  output logic [1:0] fault_pin_out,
  output logic [1:0] fault_pin_oe_n,
  output logic alert_out,
  output logic alert_oe_n,
  output logic [1:0] chan_en
);
  logic [1:0] run_m, run_s, fp_m, fp_s;
  logic sy_m, sy_s, sy_d;
  logic [7:0] sync_tmo_reg;
  logic sync_present;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic wr;
  logic [7:0] cfg_reg;
  logic [7:0] stat_reg [2];
  logic [7:0] mask_reg [2];
  logic [7:0] prop_reg [2];
  logic [5:0] com_reg, mask_com_reg;
  logic [16:0] retry_reg;
  logic [1:0] resp_reg, oper_reg;
  logic [1:0] en, en_d, en_rise;
  fsam_chan_st_e st_reg [2];
  logic [16:0] rty_reg [2];
  logic [1:0] chan_en_reg, fp_oe_n_reg;
  logic [1:0][2:0] drv_hist;
  logic [1:0] ext_live, shut, drv_next, latched;
  logic [7:0] set_ch [2];
  logic [5:0] com_set;
  logic clr_all, tog_all, alert_any, alert_oe_n_reg;
  logic [15:0] word [2];
  logic [15:0] pads;

  // outside pins: two flops each, sync a third for its edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_m <= 2'h0;
      run_s <= 2'h0;
      fp_m <= 2'h3;
      fp_s <= 2'h3;
      sy_m <= 1'b0;
      sy_s <= 1'b0;
      sy_d <= 1'b0;
    end else begin
      run_m <= run_pin;
      run_s <= run_m;
      fp_m <= fault_pin_in;
      fp_s <= fp_m;
      sy_m <= sync_pin;
      sy_s <= sy_m;
      sy_d <= sy_s;
    end
  end

  // sync seen present while edges keep coming
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      sync_tmo_reg <= 8'h00;
    else if (sy_s != sy_d)
      sync_tmo_reg <= 8'(SYNC_TMO_CYC);
    else if (sync_tmo_reg != 8'h00)
      sync_tmo_reg <= sync_tmo_reg - 8'h01;
  end
  assign sync_present = (sync_tmo_reg != 8'h00);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      ms_cnt_reg <= 32'h0;
    else if (ms_tick)
      ms_cnt_reg <= 32'h0;
    else
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
  end
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  // bus slave: one wait cycle, then the access completes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= avs_read ? rd_mux : 32'h0;
    end else begin
      wait_reg <= 1'b1;
    end
  end
  assign wr = avs_write && !wait_reg;
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // diagnostic words are read-only, never in the alert path
  // sync made inside and external sync not chosen
  assign pads = {5'h00, ~cfg_reg[CFG_EXT_SYNC] & ~cfg_reg[CFG_SYNC_DIS],
                 6'h00, run_s, fp_s};

  always_comb begin
    case (avs_address)
      OFS_CFG: rd_mux = {24'h0, cfg_reg};
      OFS_STAT0: rd_mux = {24'h0, stat_reg[0]};
      OFS_STAT1: rd_mux = {24'h0, stat_reg[1]};
      OFS_STATC: rd_mux = {26'h0, com_reg};
      OFS_MASK0: rd_mux = {24'h0, mask_reg[0]};
      OFS_MASK1: rd_mux = {24'h0, mask_reg[1]};
      OFS_MASKC: rd_mux = {26'h0, mask_com_reg};
      OFS_PROP: rd_mux = {16'h0, prop_reg[1], prop_reg[0]};
      OFS_RETRY: rd_mux = {15'h0, retry_reg};
      OFS_RESP: rd_mux = {30'h0, resp_reg};
      OFS_WORD: rd_mux = {word[1], word[0]};
      OFS_COMMON: rd_mux = {25'h0, latched, sync_present, chan_en_reg,
                            en};
      OFS_PADS: rd_mux = {16'h0, pads};
      OFS_OPER: rd_mux = {30'h0, oper_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // masks start open until software loads them
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= CFG_RST;
      mask_reg[0] <= 8'h00;
      mask_reg[1] <= 8'h00;
      mask_com_reg <= 6'h00;
      prop_reg[0] <= 8'h00;
      prop_reg[1] <= 8'h00;
      retry_reg <= RETRY_RST_MS;
      resp_reg <= RESP_RST;
      oper_reg <= OPER_RST;
    end else if (wr) begin
      case (avs_address)
        OFS_CFG: cfg_reg <= avs_writedata[7:0];
        OFS_MASK0: mask_reg[0] <= avs_writedata[7:0];
        OFS_MASK1: mask_reg[1] <= avs_writedata[7:0];
        OFS_MASKC: mask_com_reg <= avs_writedata[5:0];
        OFS_PROP: begin
          prop_reg[0] <= avs_writedata[7:0];
          prop_reg[1] <= avs_writedata[15:8];
        end
        OFS_RETRY: begin
          if (avs_writedata >= 32'(RETRY_MIN_MS) &&
              avs_writedata <= 32'(RETRY_MAX_MS))
            retry_reg <= avs_writedata[16:0];
        end
        OFS_RESP: resp_reg <= avs_writedata[1:0];
        OFS_OPER: oper_reg <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // channel on by pin and command together
  assign en = run_s & oper_reg;
  assign en_rise = en & ~en_d;
  assign tog_all = (|en_rise) & cfg_reg[CFG_RUN_CLR_ALL];
  assign clr_all = ara_ok || (wr && avs_address == OFS_CTRL &&
                   (avs_writedata[CTRL_CLR] || avs_writedata[CTRL_RST]));

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // pin low while we are quiet is an outside fault
      ext_live[i] = ~fp_s[i] & ~|drv_hist[i] & fp_oe_n_reg[i];
      set_ch[i] = {ext_live[i], chan_cond[i]};
      shut[i] = |(chan_cond[i] & SHUT_BITS) | ext_live[i] |
                com_cond.vin_ov_f;
      latched[i] = (st_reg[i] == CH_LATCH);
      // selected live indicators, latch holds the pin
      drv_next[i] = |(chan_cond[i] & prop_reg[i][6:0]) |
                    (latched[i] & |prop_reg[i][6:0]) |
                    (st_reg[i] == CH_WAIT &
                     |(stat_reg[i][6:0] & prop_reg[i][6:0]));
    end
  end

  // busy when a channel runs; clock-lock fault
  assign com_set = {unsafe_cmd & |chan_en_reg,
                    ~cfg_reg[CFG_FREQ_SEL] & ~sync_present, com_cond};

  // sticky status; a set in the clear cycle wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg[0] <= 8'h00;
      stat_reg[1] <= 8'h00;
      com_reg <= 6'h00;
      en_d <= 2'h0;
    end else begin
      en_d <= en;
      for (int i = 0; i < 2; i++) begin
        // per-bit write-one clear; toggle clears channel
        if (clr_all || en_rise[i] || tog_all)
          stat_reg[i] <= set_ch[i];
        else if (wr && avs_address == (i == 0 ? OFS_STAT0 : OFS_STAT1))
          stat_reg[i] <= (stat_reg[i] & ~avs_writedata[7:0]) | set_ch[i];
        else
          stat_reg[i] <= stat_reg[i] | set_ch[i];
      end
      if (clr_all || tog_all)
        com_reg <= com_set;
      else if (wr && avs_address == OFS_STATC)
        com_reg <= (com_reg & ~avs_writedata[5:0]) | com_set;
      else
        com_reg <= com_reg | com_set;
    end
  end

  // derived summary words, never cleared or masked themselves
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      word[i] = 16'h0000;
      word[i][15] = |stat_reg[i][3:0];
      word[i][14] = |stat_reg[i][5:4];
      word[i][13] = |com_reg[2:0];
      word[i][12] = stat_reg[i][ST_EXT] | com_reg[C_PLL];
      word[i][7] = com_reg[C_BUSY];
      word[i][2] = stat_reg[i][6];
      word[i][1] = com_reg[3];
      word[i][0] = |word[i][15:12];
    end
  end

  // per-bit mask, busy exempt; summaries add nothing
  assign alert_any = |(stat_reg[0] & ~mask_reg[0]) |
                     |(stat_reg[1] & ~mask_reg[1]) |
                     |(com_reg & ~(mask_com_reg & ~COM_UNMASK));

  // open-drain alert, output fixed low, enable carries the level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alert_oe_n_reg <= 1'b1;
      alert_out <= 1'b0;
    end else begin
      alert_oe_n_reg <= ~alert_any;
      alert_out <= 1'b0;
    end
  end
  assign alert_oe_n = alert_oe_n_reg;

  // own drive echoes through the synchroniser; blank it meanwhile
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fp_oe_n_reg <= 2'h3;
      fault_pin_out <= 2'h0;
      drv_hist <= '0;
    end else begin
      fp_oe_n_reg <= ~drv_next;
      fault_pin_out <= 2'h0;
      for (int i = 0; i < 2; i++)
        drv_hist[i] <= {drv_hist[i][1:0], ~fp_oe_n_reg[i]};
    end
  end
  assign fault_pin_oe_n = fp_oe_n_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        st_reg[i] <= CH_OFF;
        rty_reg[i] <= 17'h0;
      end
      chan_en_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        chan_en_reg[i] <= (st_reg[i] == CH_RUN);
        case (st_reg[i])
          CH_OFF: if (en[i]) st_reg[i] <= CH_RUN;
          CH_RUN: begin
            if (!en[i])
              st_reg[i] <= CH_OFF;
            else if (shut[i] && resp_reg[i])
              st_reg[i] <= CH_LATCH;
            else if (shut[i]) begin
              st_reg[i] <= CH_WAIT;
              rty_reg[i] <= 17'(retry_reg - 17'h1);
            end
          end
          // wait out the interval, restart or wait again
          CH_WAIT: begin
            if (!en[i])
              st_reg[i] <= CH_OFF;
            else if (ms_tick && rty_reg[i] != 17'h0)
              rty_reg[i] <= rty_reg[i] - 17'h1;
            else if (ms_tick && shut[i])
              rty_reg[i] <= 17'(retry_reg - 17'h1);
            else if (ms_tick)
              st_reg[i] <= CH_RUN;
          end
          // only turning the channel off frees it
          CH_LATCH: if (!en[i]) st_reg[i] <= CH_OFF;
          default: st_reg[i] <= CH_OFF;
        endcase
      end
    end
  end
  assign chan_en = chan_en_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_alert_follows: assert property (
    alert_any |=> !alert_oe_n) else $error("alert not asserted");
  a_alert_release: assert property (
    !alert_any |=> alert_oe_n) else $error("alert held without cause");
  a_ara_clears: assert property (
    (ara_ok && com_set == 6'h0 && set_ch[0] == 8'h0 && set_ch[1] == 8'h0)
    |=> (com_reg == 6'h0 && stat_reg[0] == 8'h0 && stat_reg[1] == 8'h0))
    else $error("clear event left status");
  a_fault_pin_drive: assert property (
    |(chan_cond[0] & prop_reg[0][6:0]) |=> !fault_pin_oe_n[0])
    else $error("fault pin not pulled");
  a_ext_fault_seen: assert property (
    ext_live[1] |=> stat_reg[1][ST_EXT]) else $error("external lost");
  a_retry_restart: assert property (
    (st_reg[1] == CH_WAIT && en[1] && ms_tick && rty_reg[1] == 17'h0 &&
     !shut[1]) |=> st_reg[1] == CH_RUN ##1 chan_en[1])
    else $error("no restart after interval");
  a_retry_range: assert property (
    retry_reg >= RETRY_MIN_MS && retry_reg <= RETRY_MAX_MS)
    else $error("retry interval out of range");
  a_nota_summary: assert property (
    word[1][0] == (|com_reg[2:0] | stat_reg[1][ST_EXT] | com_reg[C_PLL] |
                   |stat_reg[1][5:0])) else $error("summary bit wrong");
  a_busy_unmasked: assert property (
    (unsafe_cmd && |chan_en) |=> com_reg[C_BUSY] ##1 !alert_oe_n)
    else $error("busy not raised");
  a_pll_fault: assert property (
    (!cfg_reg[CFG_FREQ_SEL] && !sync_present) |=> com_reg[C_PLL])
    else $error("clock-lock fault missing");
  a_latch_hold: assert property (
    (latched[0] && en[0]) |=> latched[0] ##1 !chan_en[0])
    else $error("latched channel restarted");

  c_hiccup: cover property (
    st_reg[1] == CH_WAIT ##1 st_reg[1] == CH_RUN);
  c_latch: cover property (latched[0] ##1 !latched[0]);
  c_ext: cover property (ext_live[1] ##1 !alert_oe_n);
  c_masked: cover property (stat_reg[0] != 8'h0 && alert_oe_n);
endmodule : fsam_top
`default_nettype wire
